// >>> rtl/motion_pkg.sv
package motion_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_SETS = 3;
  localparam int unsigned NUM_FIELDS = 9;
  localparam int unsigned MASK_W = 13;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG_LO = 8'h04;
  localparam logic [7:0] REG_ARG_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] REG_LIMIT_OFFSET = 8'h14;
  localparam logic [7:0] REG_USER_LOC_LO = 8'h18;
  localparam logic [7:0] REG_USER_LOC_HI = 8'h1C;
  localparam logic [7:0] REG_LIMIT_LO = 8'h20;
  localparam logic [7:0] REG_LIMIT_HI = 8'h24;
  localparam logic [7:0] REG_PSET_SEL = 8'h28;
  localparam logic [7:0] REG_PSET_DATA = 8'h2C;

  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_ARG_LSB = 4;
  localparam int unsigned CMD_MASK_LSB = 16;
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_OTF_BIT = 8;
  localparam int unsigned SEL_FLD_LSB = 0;
  localparam int unsigned SEL_SET_LSB = 4;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_ERR_BIT = 1;
  localparam int unsigned ST_MOVING_BIT = 2;
  localparam int unsigned ST_STATE_LSB = 4;

  localparam logic [3:0] OP_STORE = 4'h1;
  localparam logic [3:0] OP_PRESET = 4'h2;
  localparam logic [3:0] OP_SEARCH = 4'h3;
  localparam logic [3:0] OP_LAUNCH = 4'h4;

  localparam logic [1:0] STORE_ALL = 2'h0;
  localparam logic [1:0] STORE_SEQ_TABLE = 2'h1;
  localparam logic [1:0] STORE_VARS = 2'h2;

  localparam logic [31:0] PROFILE_TRAPEZOID = 32'h0000_0000;
  localparam logic [31:0] TABLE_MODE_AMPL = 32'h0000_0001;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    FLD_TARGET   = 4'h0,
    FLD_VELOCITY = 4'h1,
    FLD_RAMP     = 4'h2,
    FLD_JERK     = 4'h3,
    FLD_PTYPE    = 4'h4,
    FLD_TNUM     = 4'h5,
    FLD_TSEL     = 4'h6,
    FLD_TTIME    = 4'h7,
    FLD_TAMP     = 4'h8
  } field_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STORE  = 2'b01,
    ST_SEARCH = 2'b10,
    ST_LAUNCH = 2'b11
  } state_e;

endpackage

// >>> rtl/param_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface param_bank_if;
  import motion_pkg::*;
  logic              wr_en;
  logic [1:0]        wr_set;
  logic [3:0]        wr_fld;
  logic [31:0]       wr_data;
  logic [1:0]        rd_set;
  logic [31:0]       rd_word [NUM_FIELDS];

  modport user (output wr_en, wr_set, wr_fld, wr_data, rd_set,
                input rd_word);
  modport bank (input wr_en, wr_set, wr_fld, wr_data, rd_set,
                output rd_word);
endinterface
`default_nettype wire

// >>> rtl/param_bank.sv
`timescale 1ns/1ps
`default_nettype none
module param_bank
  import motion_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   resetn,
  param_bank_if.bank  pb
);

  logic [31:0] mem_r [NUM_SETS][NUM_FIELDS];

  // Sets are numbered 1 to 3; set 0 does not exist and reads as zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int f = 0; f < NUM_FIELDS; f++) begin
          mem_r[s][f] <= RESET_WORD;
        end
      end
    end else if (pb.wr_en && pb.wr_set != 2'd0 &&
                 pb.wr_fld < 4'(NUM_FIELDS)) begin
      mem_r[pb.wr_set - 2'd1][pb.wr_fld] <= pb.wr_data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++) begin : g_rd
      assign pb.rd_word[g] = (pb.rd_set == 2'd0) ? RESET_WORD :
                             mem_r[pb.rd_set - 2'd1][g];
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/motion_command_executor.sv
`timescale 1ns/1ps
`default_nettype none
module motion_command_executor
  import motion_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   store_req,
  output logic                   store_seq_table,
  output logic                   store_vars_params,
  input  wire logic              store_done,
  output logic                   search_req,
  output logic      [7:0]        limit_search_mode,
  output logic      [31:0]       limit_offset_param,
  input  wire logic              search_done,
  input  wire logic [63:0]       search_pos,
  input  wire logic              moving,
  output logic                   motion_start,
  output logic      [31:0]       target_goal,
  output logic      [31:0]       profile_velocity,
  output logic      [31:0]       profile_ramp_rate,
  output logic      [31:0]       jerk_duration,
  output logic      [31:0]       profile_type,
  output logic      [31:0]       table_number,
  output logic      [31:0]       table_select_mode,
  output logic      [31:0]       table_playback_time,
  output logic      [31:0]       table_amplitude,
  output logic      [31:0]       user_location_low,
  output logic      [31:0]       user_location_high
);

  param_bank_if pb ();

  param_bank u_bank (
    .clk    (clk),
    .resetn (resetn),
    .pb     (pb)
  );

  state_e        state_r;
  logic [31:0]   arg_lo_r;
  logic [31:0]   arg_hi_r;
  logic          otf_r;
  logic [1:0]    launch_set_r;
  logic [12:0]   launch_mask_r;
  logic [3:0]    sel_fld_r;
  logic [1:0]    sel_set_r;
  logic          err_r;
  logic [31:0]   limit_lo_r;
  logic [31:0]   limit_hi_r;
  logic          wr_acc;
  logic          rd_acc;
  logic          cmd_wr;
  logic [3:0]    cmd_op;
  logic [1:0]    cmd_arg;
  logic          cmd_bad;
  logic          otf_ok;
  logic [12:0]   eff_mask;
  logic [31:0]   tsel_new;
  logic [63:0]   offset_ext;
  logic [63:0]   result_nxt;
  logic          mapped;

  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign cmd_op = pwdata[CMD_OP_LSB +: 4];
  assign cmd_arg = pwdata[CMD_ARG_LSB +: 2];
  assign cmd_wr = wr_acc && paddr == REG_CMD;

  // A command is refused while another one is still running.
  always_comb begin
    cmd_bad = 1'b0;
    if (state_r != ST_IDLE) begin
      cmd_bad = 1'b1;
    end else if (cmd_op == OP_STORE) begin
      cmd_bad = (cmd_arg != STORE_ALL) && (cmd_arg != STORE_SEQ_TABLE) &&
                (cmd_arg != STORE_VARS);
    end else if (cmd_op == OP_LAUNCH) begin
      cmd_bad = (cmd_arg == 2'd0);
    end else if (cmd_op != OP_PRESET && cmd_op != OP_SEARCH) begin
      cmd_bad = 1'b1;
    end
  end

  always_comb begin
    mapped = 1'b1;
    if (paddr == REG_CMD) begin
      mapped = 1'b1;
    end else if (paddr == REG_ARG_LO || paddr == REG_ARG_HI) begin
      mapped = 1'b1;
    end else if (paddr == REG_STATUS || paddr == REG_CONFIG) begin
      mapped = 1'b1;
    end else if (paddr == REG_LIMIT_OFFSET) begin
      mapped = 1'b1;
    end else if (paddr == REG_USER_LOC_LO || paddr == REG_USER_LOC_HI) begin
      mapped = 1'b1;
    end else if (paddr == REG_LIMIT_LO || paddr == REG_LIMIT_HI) begin
      mapped = 1'b1;
    end else if (paddr == REG_PSET_SEL || paddr == REG_PSET_DATA) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  always_comb begin
    prdata = RESET_WORD;
    if (!rd_acc) begin
      prdata = RESET_WORD;
    end else if (paddr == REG_ARG_LO) begin
      prdata = arg_lo_r;
    end else if (paddr == REG_ARG_HI) begin
      prdata = arg_hi_r;
    end else if (paddr == REG_STATUS) begin
      prdata[ST_BUSY_BIT] = state_r != ST_IDLE;
      prdata[ST_ERR_BIT] = err_r;
      prdata[ST_MOVING_BIT] = moving;
      prdata[ST_STATE_LSB +: 2] = state_r;
    end else if (paddr == REG_CONFIG) begin
      prdata[CFG_MODE_LSB +: 8] = limit_search_mode;
      prdata[CFG_OTF_BIT] = otf_r;
    end else if (paddr == REG_LIMIT_OFFSET) begin
      prdata = limit_offset_param;
    end else if (paddr == REG_USER_LOC_LO) begin
      prdata = user_location_low;
    end else if (paddr == REG_USER_LOC_HI) begin
      prdata = user_location_high;
    end else if (paddr == REG_LIMIT_LO) begin
      prdata = limit_lo_r;
    end else if (paddr == REG_LIMIT_HI) begin
      prdata = limit_hi_r;
    end else if (paddr == REG_PSET_SEL) begin
      prdata[SEL_FLD_LSB +: 4] = sel_fld_r;
      prdata[SEL_SET_LSB +: 2] = sel_set_r;
    end else if (paddr == REG_PSET_DATA) begin
      prdata = (sel_fld_r < 4'(NUM_FIELDS)) ? pb.rd_word[sel_fld_r] :
               RESET_WORD;
    end
  end

  // Software fills the parameter sets through the select and data pair.
  assign pb.wr_en = wr_acc && paddr == REG_PSET_DATA;
  assign pb.wr_set = sel_set_r;
  assign pb.wr_fld = sel_fld_r;
  assign pb.wr_data = pwdata;
  assign pb.rd_set = (state_r == ST_LAUNCH) ? launch_set_r : sel_set_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      arg_lo_r <= RESET_WORD;
      arg_hi_r <= RESET_WORD;
      limit_search_mode <= 8'h00;
      otf_r <= 1'b0;
      limit_offset_param <= RESET_WORD;
      sel_fld_r <= 4'h0;
      sel_set_r <= 2'h1;
    end else if (wr_acc) begin
      if (paddr == REG_ARG_LO) begin
        arg_lo_r <= pwdata;
      end else if (paddr == REG_ARG_HI) begin
        arg_hi_r <= pwdata;
      end else if (paddr == REG_CONFIG) begin
        limit_search_mode <= pwdata[CFG_MODE_LSB +: 8];
        otf_r <= pwdata[CFG_OTF_BIT];
      end else if (paddr == REG_LIMIT_OFFSET) begin
        limit_offset_param <= pwdata;
      end else if (paddr == REG_PSET_SEL) begin
        sel_fld_r <= pwdata[SEL_FLD_LSB +: 4];
        sel_set_r <= pwdata[SEL_SET_LSB +: 2];
      end
    end
  end

  // Error flag: a refused command sets it, writing one to it clears it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      err_r <= 1'b0;
    end else if ((cmd_wr && cmd_bad) ||
                 (state_r == ST_LAUNCH && moving && !otf_ok)) begin
      err_r <= 1'b1;
    end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      store_req <= 1'b0;
      store_seq_table <= 1'b0;
      store_vars_params <= 1'b0;
      search_req <= 1'b0;
      launch_set_r <= 2'h0;
      launch_mask_r <= 13'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_wr && !cmd_bad && cmd_op == OP_STORE) begin
            state_r <= ST_STORE;
            store_req <= 1'b1;
            store_seq_table <= cmd_arg != STORE_VARS;
            store_vars_params <= cmd_arg != STORE_SEQ_TABLE;
          end else if (cmd_wr && !cmd_bad && cmd_op == OP_SEARCH) begin
            state_r <= ST_SEARCH;
            search_req <= 1'b1;
          end else if (cmd_wr && !cmd_bad && cmd_op == OP_LAUNCH) begin
            state_r <= ST_LAUNCH;
            launch_set_r <= cmd_arg;
            launch_mask_r <= pwdata[CMD_MASK_LSB +: MASK_W];
          end
        end
        ST_STORE: begin
          if (store_done) begin
            state_r <= ST_IDLE;
            store_req <= 1'b0;
            store_seq_table <= 1'b0;
            store_vars_params <= 1'b0;
          end
        end
        ST_SEARCH: begin
          if (search_done) begin
            state_r <= ST_IDLE;
            search_req <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // The offset is handed to the search but taken back out of the result.
  assign offset_ext = {{32{limit_offset_param[31]}}, limit_offset_param};
  assign result_nxt = search_pos - offset_ext;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      limit_lo_r <= RESET_WORD;
      limit_hi_r <= RESET_WORD;
    end else if (state_r == ST_SEARCH && search_done) begin
      limit_lo_r <= result_nxt[31:0];
      limit_hi_r <= result_nxt[63:32];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      user_location_low <= RESET_WORD;
      user_location_high <= RESET_WORD;
    end else if (cmd_wr && !cmd_bad && cmd_op == OP_PRESET) begin
      user_location_low <= arg_lo_r;
      user_location_high <= arg_hi_r;
    end
  end

  // While moving, only a trapezoid move with on-the-fly change accepts a
  // launch, and then only target, velocity and ramp rate are loaded.
  assign otf_ok = otf_r && profile_type == PROFILE_TRAPEZOID;
  assign eff_mask = (launch_mask_r == 13'h0000) ? 13'h1FFF :
                    launch_mask_r;
  assign tsel_new = eff_mask[7] ? pb.rd_word[FLD_TSEL] : table_select_mode;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      motion_start <= 1'b0;
      target_goal <= RESET_WORD;
      profile_velocity <= RESET_WORD;
      profile_ramp_rate <= RESET_WORD;
      jerk_duration <= RESET_WORD;
      profile_type <= RESET_WORD;
      table_number <= RESET_WORD;
      table_select_mode <= RESET_WORD;
      table_playback_time <= RESET_WORD;
      table_amplitude <= RESET_WORD;
    end else begin
      motion_start <= 1'b0;
      if (state_r == ST_LAUNCH && (!moving || otf_ok)) begin
        motion_start <= 1'b1;
        if (eff_mask[0]) begin
          target_goal <= pb.rd_word[FLD_TARGET];
        end
        if (eff_mask[1]) begin
          profile_velocity <= pb.rd_word[FLD_VELOCITY];
        end
        if (eff_mask[2]) begin
          profile_ramp_rate <= pb.rd_word[FLD_RAMP];
        end
        // Bits 4 and 5 select nothing; they count only in the check for an all-zero mask.
        if (!moving) begin
          if (eff_mask[3]) begin
            jerk_duration <= pb.rd_word[FLD_JERK];
          end
          if (eff_mask[6]) begin
            profile_type <= pb.rd_word[FLD_PTYPE];
          end
          if (eff_mask[7]) begin
            table_number <= pb.rd_word[FLD_TNUM];
            table_select_mode <= pb.rd_word[FLD_TSEL];
          end
          if (eff_mask[8]) begin
            table_playback_time <= pb.rd_word[FLD_TTIME];
          end
          if (eff_mask[9] && tsel_new == TABLE_MODE_AMPL) begin
            table_amplitude <= pb.rd_word[FLD_TAMP];
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/motion_command_executor_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module motion_command_executor_monitor
  import motion_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              store_req,
  input wire logic              store_seq_table,
  input wire logic              store_vars_params,
  input wire logic              search_req,
  input wire logic              search_done,
  input wire logic              motion_start,
  input wire logic [31:0]       target_goal,
  input wire logic [31:0]       table_select_mode,
  input wire logic [31:0]       table_amplitude,
  input wire logic [31:0]       user_location_low
);
  logic       cmd_wr;
  logic       wr_preset;
  logic       wr_launch;
  logic [1:0] sel;

  assign cmd_wr = psel && penable && pwrite && paddr == REG_CMD;
  assign wr_preset = cmd_wr && pwdata[3:0] == OP_PRESET;
  assign wr_launch = cmd_wr && pwdata[3:0] == OP_LAUNCH;
  assign sel = pwdata[5:4];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_STORE_ALL: assert property (
    $rose(store_req) && $past(cmd_wr) && $past(sel) == STORE_ALL
    |-> store_seq_table && store_vars_params) else $error("store all");
  AST_STORE_SEQ: assert property (
    $rose(store_req) && $past(cmd_wr) && $past(sel) == STORE_SEQ_TABLE
    |-> store_seq_table && !store_vars_params) else $error("store seq");
  AST_STORE_VARS: assert property (
    $rose(store_req) && $past(cmd_wr) && $past(sel) == STORE_VARS
    |-> !store_seq_table && store_vars_params) else $error("store vars");
  AST_PRESET_ONLY: assert property (
    $changed(user_location_low) |-> $past(wr_preset))
    else $error("user position changed without preset");
  AST_SEARCH_HOLD: assert property (
    search_req && !search_done |=> search_req) else $error("search lost");
  AST_SEARCH_END: assert property (
    search_req && search_done |=> !search_req) else $error("search stuck");
  AST_LAUNCH_LAT: assert property (
    motion_start |-> $past(wr_launch, 2)) else $error("start latency");
  AST_START_PULSE: assert property (
    motion_start |=> !motion_start) else $error("start not a pulse");
  AST_LOAD_AT_START: assert property (
    $changed(target_goal) |-> motion_start) else $error("target load");
  AST_AMP_MODE: assert property (
    $changed(table_amplitude) |-> table_select_mode == TABLE_MODE_AMPL)
    else $error("amplitude outside mode");
endmodule

bind motion_command_executor motion_command_executor_monitor mon (
  .clk               (clk),
  .resetn            (resetn),
  .paddr             (paddr),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .pwdata            (pwdata),
  .store_req         (store_req),
  .store_seq_table   (store_seq_table),
  .store_vars_params (store_vars_params),
  .search_req        (search_req),
  .search_done       (search_done),
  .motion_start      (motion_start),
  .target_goal       (target_goal),
  .table_select_mode (table_select_mode),
  .table_amplitude   (table_amplitude),
  .user_location_low (user_location_low)
);
`default_nettype wire

// >>> testbench/motion_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module motion_far_end (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        store_req,
  input  wire logic        search_req,
  input  wire logic        motion_start,
  input  wire logic        slow,
  input  wire logic [63:0] found_pos,
  output logic             store_done,
  output logic             search_done,
  output logic             moving,
  output logic      [63:0] search_pos
);
  logic [5:0] wait_r;
  logic [5:0] run_r;
  logic       hit;

  // Answers after one cycle, or after thirty when slow.
  assign hit = wait_r == (slow ? 6'h1E : 6'h01);
  assign store_done = store_req && hit;
  assign search_done = search_req && hit;
  // Outside the answer cycle the position bus carries the inverse.
  assign search_pos = search_done ? found_pos : ~found_pos;
  assign moving = run_r != 6'h00;

  always_ff @(posedge clk) begin
    if (!resetn || hit || !(store_req || search_req)) begin
      wait_r <= 6'h00;
    end else begin
      wait_r <= wait_r + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_r <= 6'h00;
    end else if (motion_start) begin
      run_r <= 6'h28;
    end else if (moving) begin
      run_r <= run_r - 6'h01;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/motion_command_executor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, x) begin n_compared++; if ((a) !== (x)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, a, x); end end
module motion_command_executor_test import motion_pkg::*;;
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, slow = 1'b0, pready, pslverr, moving, e;
  logic        store_req, store_seq_table, store_vars_params, store_done;
  logic        search_req, search_done, motion_start;
  logic [7:0]  paddr = 8'h00, limit_search_mode;
  logic [31:0] pwdata = 32'h0000_0000, prdata, d, limit_offset_param;
  logic [31:0] target_goal, profile_velocity, profile_ramp_rate;
  logic [31:0] jerk_duration, profile_type, table_number, table_select_mode;
  logic [31:0] table_playback_time, table_amplitude, outs [9], want [9];
  logic [31:0] user_location_low, user_location_high;
  logic [63:0] found_pos = 64'h0000_0000_0000_0000, search_pos;
  int          fail_count = 0, n_compared = 0;
  int          bits [10] = '{4, 5, 0, 1, 2, 3, 6, 7, 8, 9};
  int          fld [10] = '{0, 1, 2, 3, -1, -1, 4, 5, 7, 8};

  always #25 clk = ~clk;
  always_comb outs = '{target_goal, profile_velocity, profile_ramp_rate,
    jerk_duration, profile_type, table_number, table_select_mode,
    table_playback_time, table_amplitude};

  motion_command_executor dut (.*);
  motion_far_end far (.*);

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    paddr <= a;
    pwdata <= v;
    pwrite <= w;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] fval(input int s, input int f);
    fval = 32'h0000_0100 * s + f;
    if (f == 6) fval = 32'h0000_0001;
    if (f == 4 && s == 2) fval = 32'h0000_0000;
  endfunction

  task automatic wait_idle();
    int n = 0;
    @(posedge clk);
    while ((store_req | search_req | moving) !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic launch(input logic [1:0] s, input logic [12:0] m,
                        input logic st);
    int n = 0;
    apb(1'b1, REG_CMD, {3'h0, m, 10'h000, s, OP_LAUNCH});
    do begin
      @(negedge clk);
      n++;
    end while (motion_start !== 1'b1 && n < 6);
    `CHK(motion_start, st)
    for (int f = 0; f < 9; f++) `CHK(outs[f], want[f])
    @(posedge clk);
  endtask

  task automatic test_store();
    for (int s = 0; s < 3; s++) begin
      slow <= s[0];
      apb(1'b1, REG_CMD, 32'(s * 16) + 32'(OP_STORE));
      @(negedge clk);
      `CHK({store_seq_table, store_vars_params}, {s != 2, s != 1})
      wait_idle();
      `CHK(store_req, 1'b0)
    end
    apb(1'b1, REG_CMD, 32'h0000_0031);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK(d[ST_ERR_BIT], 1'b1)
    apb(1'b1, REG_STATUS, 32'h0000_0002);
    apb(1'b1, REG_CMD, {28'h000_0000, OP_LAUNCH});
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK({d[ST_ERR_BIT], d[ST_BUSY_BIT]}, 2'b10)
    apb(1'b1, REG_STATUS, 32'h0000_0002);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    `CHK({e, d}, {1'b1, 32'h0000_0000})
  endtask

  task automatic test_preset_search();
    apb(1'b1, REG_ARG_LO, 32'h1234_5678);
    apb(1'b1, REG_ARG_HI, 32'h0000_00AB);
    apb(1'b1, REG_CMD, {28'h000_0000, OP_PRESET});
    `CHK(user_location_high, 32'h0000_00AB)
    `CHK(user_location_low, 32'h1234_5678)
    apb(1'b1, REG_CONFIG, 32'h0000_0005);
    apb(1'b1, REG_LIMIT_OFFSET, 32'hFFFF_FFFB);
    found_pos <= 64'h0000_0001_0000_0100;
    slow <= 1'b1;
    apb(1'b1, REG_CMD, {28'h000_0000, OP_SEARCH});
    `CHK({search_req, limit_search_mode}, 9'h105)
    `CHK(limit_offset_param, 32'hFFFF_FFFB)
    wait_idle();
    apb(1'b0, REG_LIMIT_LO, 32'h0000_0000);
    `CHK(d, 32'h0000_0105)
    apb(1'b0, REG_LIMIT_HI, 32'h0000_0000);
    `CHK(d, 32'h0000_0001)
  endtask

  task automatic test_launch();
    int b;
    for (int s = 2; s < 4; s++) begin
      for (int f = 0; f < 9; f++) begin
        apb(1'b1, REG_PSET_SEL, 32'(s * 16 + f));
        apb(1'b1, REG_PSET_DATA, fval(s, f));
      end
    end
    for (int f = 0; f < 9; f++) want[f] = fval(2, f);
    launch(2'h2, 13'h0000, 1'b1);
    for (int i = 0; i < 10; i++) begin
      b = bits[i];
      wait_idle();
      if (fld[b] >= 0) want[fld[b]] = fval(3, fld[b]);
      if (b == 7) want[6] = fval(3, 6);
      launch(2'h3, 13'(1 << b), 1'b1);
    end
    wait_idle();
    apb(1'b1, REG_CONFIG, 32'h0000_0105);
    for (int f = 0; f < 9; f++) want[f] = fval(2, f);
    launch(2'h2, 13'h0000, 1'b1);
    for (int f = 0; f < 3; f++) want[f] = fval(3, f);
    launch(2'h3, 13'h000F, 1'b1);
    apb(1'b1, REG_CONFIG, 32'h0000_0005);
    launch(2'h2, 13'h0001, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK(d[ST_ERR_BIT], 1'b1)
    wait_idle();
    want[5] = 32'h0000_0000;
    want[6] = 32'h0000_0000;
    launch(2'h1, 13'h0280, 1'b1);
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_store();
    $display("store test ended");
    test_preset_search();
    $display("preset and search test ended");
    test_launch();
    $display("launch test ended");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
